// ===== rtl/dmacr_core.sv
// Control-byte decoder and status/counter readback sequencer
//
// Functional notes
// RULE_01: Status reinit sets match and block bits.
// RULE_02: Bit 0 shows bus requested since load.
// RULE_03: Bit 1 shows ready at programmed polarity.
// RULE_04: Bit 3 is inverted interrupt pending latch.
// RULE_05: Bit 4 drops on match, reset restores.
// RULE_06: Bit 5 drops on end of block.
// RULE_07: Undefined status bits read zero.
// RULE_08: Load command clears bus-requested bit.
// RULE_09: Reset-disable-interrupts clears pending indication.
// RULE_10: Host disables before status reinit after stop.
// RULE_11: Mask-follows routes next byte to mask.
// RULE_12: Mask selects registers, ascending, skipping others.
// RULE_13: Initiate points at lowest selected register.
// RULE_14: Host finishes sequence before restarting it.
// RULE_15: Pointer held across other commands and cycles.
// RULE_16: Read-status makes next read the status.
// RULE_17: Forced ready substitutes in burst mode.
// RULE_18: Forced ready cleared by listed events.
// RULE_19: Enable only enables bus requests.
// RULE_20: Any other control byte disables requests.
// RULE_21: Disable stops requests until re-enabled.
// RULE_22: Host writes enable as final access.
// RULE_23: Registers 1..6 are counters, low first.
// RULE_24: Byte counter cleared only by commands.
`timescale 1ns/1ps
module dmacr_core (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic wr_stb_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr3_enable_i,
    input wire logic rd_stb_i,
    output logic [7:0] rd_data_o,
    input wire logic rdy_pin_i,
    input wire logic rdy_high_i,
    input wire logic burst_i,
    input wire logic ip_latch_i,
    input wire logic byte_inc_i,
    input wire dmacr_pkg::dmacr_evt_t evt_i,
    input wire logic [15:0] port_a_addr_i,
    input wire logic [15:0] port_b_addr_i,
    output dmacr_pkg::dmacr_ctl_t ctl_o,
    output dmacr_pkg::dmacr_cmd_t cmd_o,
    output logic [15:0] byte_count_o
);
    import dmacr_pkg::*;

    typedef struct packed {
        logic rdy_s1;
        logic rdy_s2;
        logic req_seen;
        logic no_match;
        logic no_eob;
        logic force_rdy;
        logic bus_en;
        logic mask_wait;
        logic [6:0] mask;
        logic [2:0] ptr;
        dmacr_src_t src;
        logic [7:0] rd_data;
        logic cmd_stb;
        logic [7:0] cmd_code;
    } dmacr_state_t;

    localparam dmacr_state_t STATE_RST = '{
        rdy_s1: 1'b0,
        rdy_s2: 1'b0,
        req_seen: 1'b0,
        no_match: 1'b1,
        no_eob: 1'b1,
        force_rdy: 1'b0,
        bus_en: 1'b0,
        mask_wait: 1'b0,
        mask: READ_MASK_RST,
        ptr: REG_STATUS_FLAGS,
        src: DMACR_SRC_SEQ,
        rd_data: 8'h00,
        cmd_stb: 1'b0,
        cmd_code: 8'h00
    };

    dmacr_state_t q, d;
    logic cnt_clr;
    logic [15:0] count_w;
    logic rdy_act;
    logic [7:0] status_w;
    logic is_cmd;

    // RULE_12: next selected register, wrapping
    function automatic logic [2:0] next_sel(input logic [6:0] m, input logic [2:0] cur);
        logic [2:0] r;
        logic [2:0] j;
        logic found;
        r = cur;
        j = cur;
        found = 1'b0;
        for (int i = 0; i < RD_REGS; i++) begin
            j = (j == REG_LAST) ? REG_STATUS_FLAGS : j + 3'h1;
            if (!found && m[j]) begin
                r = j;
                found = 1'b1;
            end
        end
        return r;
    endfunction

    // RULE_13: lowest selected register
    function automatic logic [2:0] first_sel(input logic [6:0] m);
        return next_sel(m, REG_LAST);
    endfunction

    dmacr_byte_counter u_count (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .clr_i(cnt_clr),
        .inc_i(byte_inc_i),
        .count_o(count_w)
    );

    // RULE_03: synchronised pin against polarity
    assign rdy_act = (q.rdy_s2 == rdy_high_i);

    // RULE_07: undefined bits tied low
    always_comb begin
        status_w = 8'h00;
        // RULE_02: bus requested since load
        status_w[ST_REQUESTED] = q.req_seen;
        status_w[ST_READY] = rdy_act;
        // RULE_04: pending latch inverted
        status_w[ST_INT_IDLE] = !ip_latch_i;
        status_w[ST_NO_MATCH] = q.no_match;
        status_w[ST_NO_EOB] = q.no_eob;
    end

    // A mask byte or an enabling third-group byte is never a command
    assign is_cmd = wr_stb_i && !q.mask_wait && !wr3_enable_i
        && ((wr_data_i & CMD_BASE_MASK) == CMD_BASE);

    // RULE_23: readable register map
    function automatic logic [7:0] reg_byte(input logic [2:0] idx, input logic [7:0] st,
                                            input logic [15:0] bc, input logic [15:0] pa,
                                            input logic [15:0] pb);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            REG_STATUS_FLAGS: v = st;
            REG_BYTE_COUNT_LOW: v = bc[7:0];
            REG_BYTE_COUNT_HIGH: v = bc[15:8];
            REG_PORT_A_LOW: v = pa[7:0];
            REG_PORT_A_HIGH: v = pa[15:8];
            REG_PORT_B_LOW: v = pb[7:0];
            REG_PORT_B_HIGH: v = pb[15:8];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        d = q;
        cnt_clr = 1'b0;
        d.cmd_stb = 1'b0;
        d.rdy_s1 = rdy_pin_i;
        d.rdy_s2 = q.rdy_s1;

        // Reads go first so a command in the same cycle wins
        if (rd_stb_i) begin
            unique case (q.src)
                DMACR_SRC_STATUS: begin
                    // RULE_16: one status read, then back to sequence
                    d.rd_data = status_w;
                    d.src = DMACR_SRC_SEQ;
                end
                DMACR_SRC_SEQ: begin
                    // RULE_12: return selected, step to next
                    d.rd_data = q.mask[q.ptr]
                        ? reg_byte(q.ptr, status_w, count_w, port_a_addr_i, port_b_addr_i)
                        : 8'h00;
                    d.ptr = next_sel(q.mask, q.ptr);
                end
            endcase
        end

        if (wr_stb_i) begin
            // RULE_20: every control byte except the enabling ones disables requests
            d.bus_en = 1'b0;
            if (q.mask_wait) begin
                // RULE_11: byte lands in read mask
                d.mask = wr_data_i[6:0];
                d.mask_wait = 1'b0;
            end else if (wr3_enable_i) begin
                // RULE_19: third-group enabling bit
                d.bus_en = 1'b1;
            end else if (is_cmd) begin
                d.cmd_stb = 1'b1;
                d.cmd_code = wr_data_i;
                // RULE_15: of the commands, only initiate-sequence moves the pointer
                case (wr_data_i)
                    CMD_REINIT_STATUS: begin
                        // RULE_01: bits 4 and 5 to one
                        d.no_match = 1'b1;
                        d.no_eob = 1'b1;
                    end
                    CMD_MASK_FOLLOWS: begin
                        d.mask_wait = 1'b1;
                    end
                    CMD_INIT_SEQ: begin
                        // RULE_13: point at lowest selected
                        d.ptr = first_sel(q.mask);
                        d.src = DMACR_SRC_SEQ;
                    end
                    CMD_READ_STATUS: begin
                        d.src = DMACR_SRC_STATUS;
                    end
                    CMD_FORCE_READY: begin
                        d.force_rdy = 1'b1;
                    end
                    CMD_ENABLE_DMA: begin
                        // RULE_19: enable touches nothing else
                        d.bus_en = 1'b1;
                    end
                    CMD_RESET: begin
                        // RULE_18: reset unforces ready
                        d.no_match = 1'b1;
                        d.no_eob = 1'b1;
                        d.force_rdy = 1'b0;
                        cnt_clr = 1'b1;
                    end
                    CMD_LOAD: begin
                        // RULE_08: load clears bus-requested bit
                        d.req_seen = 1'b0;
                        d.no_eob = 1'b1;
                        d.force_rdy = 1'b0;
                        cnt_clr = 1'b1;
                    end
                    CMD_CONTINUE: begin
                        d.no_eob = 1'b1;
                        cnt_clr = 1'b1;
                    end
                    CMD_RESET_DIS_INT: begin
                        // RULE_09: pending latch cleared via strobe
                        d.force_rdy = 1'b0;
                    end
                    // RULE_21: disable and others just leave requests off
                    default: begin
                    end
                endcase
            end
        end

        // Hardware events last, so an event beats a same-cycle command
        // RULE_05: match found
        if (evt_i.match) begin
            d.no_match = 1'b0;
            d.force_rdy = 1'b0;
        end
        // RULE_06: end of block reached
        if (evt_i.eob) begin
            d.no_eob = 1'b0;
            d.force_rdy = 1'b0;
        end
        // RULE_02: bus requested
        if (evt_i.bus_req) begin
            d.req_seen = 1'b1;
        end
        // RULE_18: bus release unforces ready in every mode
        if (evt_i.bus_rel) begin
            d.force_rdy = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    assign rd_data_o = q.rd_data;
    assign cmd_o = '{stb: q.cmd_stb, code: q.cmd_code};
    assign byte_count_o = count_w;
    // RULE_17: forced ready only counts in burst mode
    assign ctl_o = '{bus_en: q.bus_en, force_rdy: q.force_rdy,
                     ready_ok: rdy_act || (q.force_rdy && burst_i)};

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    chk_reinit_bits: assert property ( // RULE_01
        is_cmd && wr_data_i == CMD_REINIT_STATUS && !evt_i.match && !evt_i.eob
        |=> status_w[ST_NO_MATCH] && status_w[ST_NO_EOB])
        else $error("status reinit did not set bits");

    chk_req_seen: assert property ( // RULE_02
        evt_i.bus_req |=> status_w[ST_REQUESTED])
        else $error("bus request not recorded");

    chk_ready_bit: assert property ( // RULE_03
        $stable(rdy_pin_i)[*3] ##0 $stable(rdy_high_i)
        |-> status_w[ST_READY] == (rdy_pin_i == rdy_high_i))
        else $error("ready bit wrong");

    chk_status_read: assert property ( // RULE_16
        rd_stb_i && q.src == DMACR_SRC_STATUS
        |=> rd_data_o == $past(status_w) && rd_data_o[7:6] == 2'b00 && !rd_data_o[2]
            && rd_data_o[ST_INT_IDLE] == !$past(ip_latch_i))
        else $error("status read wrong");

    chk_match_bit: assert property ( // RULE_05
        evt_i.match |=> !status_w[ST_NO_MATCH] && !q.force_rdy)
        else $error("match not flagged");

    chk_eob_bit: assert property ( // RULE_06
        evt_i.eob |=> !status_w[ST_NO_EOB] && !q.force_rdy)
        else $error("end of block not flagged");

    chk_load_clear: assert property ( // RULE_08
        is_cmd && wr_data_i == CMD_LOAD && !evt_i.bus_req
        |=> !status_w[ST_REQUESTED] ##1 byte_count_o <= 16'h0001)
        else $error("load did not clear");

    chk_mask_route: assert property ( // RULE_11
        wr_stb_i && q.mask_wait |=> q.mask == $past(wr_data_i[6:0]) && !cmd_o.stb)
        else $error("mask byte misrouted");

    chk_seq_start: assert property ( // RULE_13
        is_cmd && wr_data_i == CMD_INIT_SEQ && q.mask != 7'h00
        |=> q.mask[q.ptr] && (q.mask & ~(7'h7f << q.ptr)) == 7'h00 && q.src == DMACR_SRC_SEQ)
        else $error("sequence start wrong");

    chk_enable_on: assert property ( // RULE_19
        wr_stb_i && !q.mask_wait && (wr3_enable_i || wr_data_i == CMD_ENABLE_DMA)
        |=> ctl_o.bus_en)
        else $error("enable failed");

    chk_other_off: assert property ( // RULE_20
        wr_stb_i && !wr3_enable_i && !(is_cmd && wr_data_i == CMD_ENABLE_DMA)
        |=> !ctl_o.bus_en)
        else $error("control byte left requests on");

    chk_release_unforce: assert property ( // RULE_18
        evt_i.bus_rel |=> !ctl_o.force_rdy)
        else $error("release kept forced ready");
endmodule

// ===== rtl/dmacr_pkg.sv
// Shared constants and types for the DMA command and readback block
package dmacr_pkg;
    // Command group: bits 7, 1 and 0 set
    localparam logic [7:0] CMD_BASE_MASK = 8'h83;
    localparam logic [7:0] CMD_BASE = 8'h83;
    localparam logic [7:0] CMD_REINIT_STATUS = 8'h8b;
    localparam logic [7:0] CMD_MASK_FOLLOWS = 8'hbb;
    localparam logic [7:0] CMD_INIT_SEQ = 8'ha7;
    localparam logic [7:0] CMD_READ_STATUS = 8'hbf;
    localparam logic [7:0] CMD_FORCE_READY = 8'hb3;
    localparam logic [7:0] CMD_ENABLE_DMA = 8'h87;
    localparam logic [7:0] CMD_DISABLE_DMA = 8'h83;
    localparam logic [7:0] CMD_RESET = 8'hc3;
    localparam logic [7:0] CMD_LOAD = 8'hcf;
    localparam logic [7:0] CMD_CONTINUE = 8'hd3;
    localparam logic [7:0] CMD_RESET_DIS_INT = 8'ha3;

    // Readable register indices, in read order
    localparam int RD_REGS = 7;
    localparam logic [2:0] REG_STATUS_FLAGS = 3'h0;
    localparam logic [2:0] REG_BYTE_COUNT_LOW = 3'h1;
    localparam logic [2:0] REG_BYTE_COUNT_HIGH = 3'h2;
    localparam logic [2:0] REG_PORT_A_LOW = 3'h3;
    localparam logic [2:0] REG_PORT_A_HIGH = 3'h4;
    localparam logic [2:0] REG_PORT_B_LOW = 3'h5;
    localparam logic [2:0] REG_PORT_B_HIGH = 3'h6;
    localparam logic [2:0] REG_LAST = 3'h6;

    // Status byte field positions
    localparam int ST_REQUESTED = 0;
    localparam int ST_READY = 1;
    localparam int ST_INT_IDLE = 3;
    localparam int ST_NO_MATCH = 4;
    localparam int ST_NO_EOB = 5;

    // Reset values and counter step
    localparam logic [6:0] READ_MASK_RST = 7'h7f;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_STEP = 16'h0001;

    typedef enum logic {
        DMACR_SRC_SEQ = 1'b0,
        DMACR_SRC_STATUS = 1'b1
    } dmacr_src_t;

    // Same-clock events from the transfer engine
    typedef struct packed {
        logic eob;
        logic match;
        logic bus_req;
        logic bus_rel;
    } dmacr_evt_t;

    // Controls toward the transfer engine
    typedef struct packed {
        logic bus_en;
        logic force_rdy;
        logic ready_ok;
    } dmacr_ctl_t;

    // Decoded command byte, one-cycle strobe
    typedef struct packed {
        logic stb;
        logic [7:0] code;
    } dmacr_cmd_t;
endpackage

// ===== rtl/dmacr_byte_counter.sv
// Sixteen-bit transfer byte counter with command clear
`timescale 1ns/1ps
module dmacr_byte_counter (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic inc_i,
    output logic [15:0] count_o
);
    import dmacr_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
    } dmacr_cnt_state_t;

    dmacr_cnt_state_t q, d;

    always_comb begin
        d = q;
        // RULE_24: clear by commands only
        if (clr_i) begin
            d.cnt = COUNT_RST;
        end else if (inc_i) begin
            d.cnt = q.cnt + COUNT_STEP;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '{cnt: COUNT_RST};
        end else begin
            q <= d;
        end
    end

    assign count_o = q.cnt;

    // RULE_24: counter cleared by command
    chk_count_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        clr_i |=> count_o == COUNT_RST)
        else $error("byte counter not cleared");
endmodule

// ===== test/dmacr_host_model.sv
// Host processor model issuing port writes and reads
`timescale 1ns/1ps
module dmacr_host_model (
    input wire logic ref_clk_i,
    output logic wr_stb_o,
    output logic [7:0] wr_data_o,
    output logic wr3_enable_o,
    output logic rd_stb_o,
    input wire logic [7:0] rd_data_i
);
    import dmacr_pkg::*;

    initial begin
        wr_stb_o = 1'b0;
        wr_data_o = 8'h5a;
        wr3_enable_o = 1'b0;
        rd_stb_o = 1'b0;
    end

    // Released data shows the inverse, never the stale byte
    task automatic wr_byte(input logic [7:0] b, input logic en3);
        @(posedge ref_clk_i);
        wr_stb_o <= 1'b1;
        wr_data_o <= b;
        wr3_enable_o <= en3;
        @(posedge ref_clk_i);
        wr_stb_o <= 1'b0;
        wr_data_o <= ~b;
        wr3_enable_o <= 1'b0;
        @(negedge ref_clk_i);
    endtask

    task automatic rd_byte(output logic [7:0] v);
        @(posedge ref_clk_i);
        rd_stb_o <= 1'b1;
        @(posedge ref_clk_i);
        rd_stb_o <= 1'b0;
        @(negedge ref_clk_i);
        v = rd_data_i;
    endtask

    task automatic reinit_status();
        wr_byte(CMD_DISABLE_DMA, 1'b0);
        wr_byte(CMD_REINIT_STATUS, 1'b0);
    endtask

    task automatic finish_access();
        wr_byte(CMD_ENABLE_DMA, 1'b0);
    endtask
endmodule

// ===== test/dmacr_core_tb_top.sv
// Self-checking bench for the DMA command and readback block
`timescale 1ns/1ps
module dmacr_core_tb_top;
    import dmacr_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr_stb;
    logic wr3_en;
    logic rd_stb;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic rdy_pin = 1'b0;
    logic rdy_high = 1'b1;
    logic burst = 1'b0;
    logic ip_latch = 1'b0;
    logic byte_inc = 1'b0;
    dmacr_evt_t evt = '0;
    logic [15:0] port_a = 16'h1234;
    logic [15:0] port_b = 16'hbeef;
    dmacr_ctl_t ctl;
    dmacr_cmd_t cmd;
    logic [15:0] byte_count;
    logic [7:0] last_cmd = 8'h00;
    logic [7:0] v;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] clr_cmds [3] = '{CMD_LOAD, CMD_RESET_DIS_INT, CMD_RESET};
    dmacr_evt_t clr_evts [3] = '{4'b1000, 4'b0100, 4'b0001};

    dmacr_core uut (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr_stb_i(wr_stb),
        .wr_data_i(wr_data),
        .wr3_enable_i(wr3_en),
        .rd_stb_i(rd_stb),
        .rd_data_o(rd_data),
        .rdy_pin_i(rdy_pin),
        .rdy_high_i(rdy_high),
        .burst_i(burst),
        .ip_latch_i(ip_latch),
        .byte_inc_i(byte_inc),
        .evt_i(evt),
        .port_a_addr_i(port_a),
        .port_b_addr_i(port_b),
        .ctl_o(ctl),
        .cmd_o(cmd),
        .byte_count_o(byte_count)
    );

    dmacr_host_model host (
        .ref_clk_i(ref_clk_i),
        .wr_stb_o(wr_stb),
        .wr_data_o(wr_data),
        .wr3_enable_o(wr3_en),
        .rd_stb_o(rd_stb),
        .rd_data_i(rd_data)
    );

    always #10 ref_clk_i = ~ref_clk_i;

    // Downstream latch clearing keys on the strobed code
    always @(posedge ref_clk_i) begin
        if (cmd.stb === 1'b1) begin
            last_cmd <= cmd.code;
        end
    end

    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles >= 5000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(string name, logic [15:0] exp, logic [15:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            mismatches++;
        end
    endtask

    task automatic wt(int n);
        repeat (n) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask

    task automatic status(logic [7:0] exp);
        host.wr_byte(CMD_READ_STATUS, 1'b0);
        host.rd_byte(v);
        check("status_flags", 16'(exp), 16'(v));
    endtask

    task automatic rd_exp(string name, logic [7:0] exp);
        host.rd_byte(v);
        check(name, 16'(exp), 16'(v));
    endtask

    // every started sequence is read through
    task automatic seq(logic [7:0] mask);
        host.wr_byte(CMD_MASK_FOLLOWS, 1'b0);
        host.wr_byte(mask, 1'b0);
        host.wr_byte(CMD_INIT_SEQ, 1'b0);
    endtask

    task automatic pulse(dmacr_evt_t e);
        @(posedge ref_clk_i);
        evt <= e;
        @(posedge ref_clk_i);
        evt <= '0;
        @(negedge ref_clk_i);
    endtask

    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        wt(3);
        status(8'h38);
        @(posedge ref_clk_i) rdy_pin <= 1'b1;
        wt(3);
        status(8'h3a);
        @(posedge ref_clk_i) rdy_high <= 1'b0;
        wt(1);
        status(8'h38);
        @(posedge ref_clk_i) begin
            rdy_pin <= 1'b0;
            rdy_high <= 1'b1;
        end
        wt(3);
        pulse(4'b0010);
        status(8'h39);
        pulse(4'b0100);
        status(8'h29);
        pulse(4'b1000);
        status(8'h09);
        @(posedge ref_clk_i) ip_latch <= 1'b1;
        wt(1);
        status(8'h01);
        host.reinit_status();
        status(8'h31);
        host.wr_byte(CMD_LOAD, 1'b0);
        status(8'h30);
        host.wr_byte(CMD_RESET_DIS_INT, 1'b0);
        wt(1);
        check("last_cmd", 16'(CMD_RESET_DIS_INT), 16'(last_cmd));
        @(posedge ref_clk_i) ip_latch <= 1'b0;
        wt(1);
        status(8'h38);
        // Request enable and the many ways to drop it
        host.wr_byte(CMD_ENABLE_DMA, 1'b0);
        check("bus_en", 16'h0001, 16'(ctl.bus_en));
        host.wr_byte(CMD_REINIT_STATUS, 1'b0);
        check("bus_en", 16'h0000, 16'(ctl.bus_en));
        host.wr_byte(CMD_ENABLE_DMA, 1'b0);
        host.wr_byte(CMD_DISABLE_DMA, 1'b0);
        check("bus_en", 16'h0000, 16'(ctl.bus_en));
        host.wr_byte(8'hc0, 1'b1);
        check("bus_en", 16'h0001, 16'(ctl.bus_en));
        repeat (3) begin
            @(posedge ref_clk_i) byte_inc <= 1'b1;
            @(posedge ref_clk_i) byte_inc <= 1'b0;
        end
        wt(1);
        check("byte_count", 16'h0003, byte_count);
        // Mask byte equal to the enable code must not enable
        host.wr_byte(CMD_MASK_FOLLOWS, 1'b0);
        host.wr_byte(CMD_ENABLE_DMA, 1'b0);
        check("bus_en", 16'h0000, 16'(ctl.bus_en));
        host.wr_byte(CMD_INIT_SEQ, 1'b0);
        rd_exp("status_flags", 8'h38);
        rd_exp("byte_count_low", 8'h03);
        rd_exp("byte_count_high", 8'h00);
        rd_exp("status_flags", 8'h38);
        host.wr_byte(CMD_CONTINUE, 1'b0);
        wt(1);
        check("byte_count", 16'h0000, byte_count);
        seq(8'h19);
        rd_exp("status_flags", 8'h38);
        rd_exp("port_a_addr_count_low", 8'h34);
        rd_exp("port_a_addr_count_high", 8'h12);
        seq(8'h78);
        rd_exp("port_a_addr_count_low", 8'h34);
        host.wr_byte(CMD_DISABLE_DMA, 1'b0);
        host.wr_byte(CMD_FORCE_READY, 1'b0);
        pulse(4'b0010);
        pulse(4'b0001);
        rd_exp("port_a_addr_count_high", 8'h12);
        rd_exp("port_b_addr_count_low", 8'hef);
        rd_exp("port_b_addr_count_high", 8'hbe);
        // Forced ready and each event that withdraws it
        @(posedge ref_clk_i) burst <= 1'b1;
        wt(1);
        check("ready_ok", 16'h0000, 16'(ctl.ready_ok));
        for (int i = 0; i < 6; i++) begin
            host.wr_byte(CMD_FORCE_READY, 1'b0);
            check("ready_ok", 16'h0001, 16'(ctl.ready_ok));
            if (i < 3) begin
                host.wr_byte(clr_cmds[i], 1'b0);
            end else begin
                pulse(clr_evts[i - 3]);
            end
            check("force_rdy", 16'h0000, 16'(ctl.force_rdy));
        end
        @(posedge ref_clk_i) burst <= 1'b0;
        host.wr_byte(CMD_FORCE_READY, 1'b0);
        check("ready_ok", 16'h0000, 16'(ctl.ready_ok));
        // Mid-run reset restores flags, mask and pointer
        @(posedge ref_clk_i) rst_i <= 1'b1;
        @(posedge ref_clk_i) rst_i <= 1'b0;
        wt(1);
        rd_exp("status_flags", 8'h38);
        host.finish_access();
        check("bus_en", 16'h0001, 16'(ctl.bus_en));
        stop_test();
    end
endmodule
